// [dax_regs.svh]
`ifndef DAX_REGS_SVH
`define DAX_REGS_SVH

// Register byte offsets
`define DAX_OFF_CTRL       8'h00
`define DAX_OFF_INSTR      8'h04
`define DAX_OFF_OPA_LO     8'h08
`define DAX_OFF_OPA_HI     8'h0c
`define DAX_OFF_OPB_LO     8'h10
`define DAX_OFF_OPB_HI     8'h14
`define DAX_OFF_DSPCTL     8'h18
`define DAX_OFF_STATUS     8'h1c
`define DAX_OFF_ACC_BASE   8'h20
`define DAX_OFF_RES_LO     8'h40
`define DAX_OFF_RES_HI     8'h44
`define DAX_OFF_MADDR_LO   8'h48
`define DAX_OFF_MADDR_HI   8'h4c

// Control register fields
`define DAX_CTRL_GO        0
`define DAX_CTRL_EN        1

// Status register fields
`define DAX_STAT_BUSY      0
`define DAX_STAT_DONE      1
`define DAX_STAT_EXC_LSB   4

// DSP control register fields
`define DAX_DSP_POS_LSB    0
`define DAX_DSP_SCOUNT_LSB 7
`define DAX_DSP_OUFLAG     23

// Reset values
`define DAX_CTRL_RST       1'b0
`define DAX_DSPCTL_RST     32'h0000_0000

// Instruction encodings
`define DAX_OPC_PRIMARY    6'h1f
`define DAX_FN_EXTRACT     6'h38
`define DAX_FN_INSERT      6'h0c
`define DAX_FN_LOAD        6'h0a
`define DAX_SUB_XWORD      5'h01
`define DAX_SUB_XROUND     5'h05
`define DAX_SUB_XRSAT      5'h07
`define DAX_SUB_XHALF      5'h0f
`define DAX_SUB_LUBYTE     5'h06
`define DAX_SUB_LDWORD     5'h08

// Saturation limits
`define DAX_WORD_MAX       32'h7fff_ffff
`define DAX_WORD_MIN       32'h8000_0000
`define DAX_HALF_MAX       64'h0000_0000_0000_7fff
`define DAX_HALF_MIN       64'hffff_ffff_ffff_8000

`endif

// [dax_pkg.sv]
package dax_pkg;

	typedef enum logic [2:0]
	{
		exc_none,
		exc_reserved,
		exc_dsp_disabled,
		exc_tlb_refill,
		exc_tlb_invalid,
		exc_bus_error,
		exc_addr_error,
		exc_watch
	} dax_exc_t;

	typedef enum logic [1:0]
	{
		xop_word,
		xop_round,
		xop_round_sat,
		xop_half
	} dax_xop_t;

	typedef enum logic
	{
		st_idle,
		st_mem
	} dax_state_t;

endpackage

// [dax_extract.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dax_regs.svh"

module dax_extract
(
	// Operands
	input  wire logic [63:0]       acc,
	input  wire logic [4:0]        shift,
	input  wire dax_pkg::dax_xop_t xop,
	// Result
	output logic [63:0]            result,
	output logic                   ovf
);
	import dax_pkg::*;

	logic signed [64:0] t1;
	logic signed [64:0] t2;
	logic signed [63:0] h;
	logic               ovf1;
	logic               ovf2;
	logic [31:0]        word;

	always_comb
	begin
		// Shift of acc with a zero appended keeps the bit below the last kept one
		t1   = $signed({acc, 1'b0}) >>> shift;
		t2   = t1 + 65'sd1;
		ovf1 = !((t1[64:32] == 33'h0) || (&t1[64:32]));
		ovf2 = !((t2[64:32] == 33'h0) || (&t2[64:32]));
		h    = $signed(acc) >>> shift;
		word = t1[32:1];
		result = 64'h0;
		ovf  = 1'b0;
		unique case (xop)
			xop_word:
			begin
				word = t1[32:1];
				ovf  = ovf1 | ovf2;
				result = {{32{word[31]}}, word};
			end
			xop_round:
			begin
				word = t2[32:1];
				ovf  = ovf1 | ovf2;
				result = {{32{word[31]}}, word};
			end
			xop_round_sat:
			begin
				word = t2[32:1];
				if (ovf2)
					word = t2[64] ? `DAX_WORD_MIN : `DAX_WORD_MAX;
				ovf  = ovf1 | ovf2;
				result = {{32{word[31]}}, word};
			end
			xop_half:
			begin
				// Clamp to signed 16 bits, result already 64-bit sign extended
				if (h > $signed(`DAX_HALF_MAX))
				begin
					result = `DAX_HALF_MAX;
					ovf    = 1'b1;
				end
				else if (h < $signed(`DAX_HALF_MIN))
				begin
					result = `DAX_HALF_MIN;
					ovf    = 1'b1;
				end
				else
					result = h;
			end
		endcase
	end

endmodule
`default_nettype wire

// [dax_top.sv]
// Functional notes
// - Shift amount is low five bits only
// - Halfword extract shifts, clamps to 16 bits, sign-extends
// - Halfword clamp sets control bit 23
// - Selector picks one of four accumulators, unchanged
// - Word overflow when bits 64..32 not uniform
// - Rounding adds one, rechecks, takes bits 32..1
// - Saturating round clamps to max or min word
// - No data exceptions; bad operands give unpredictable results
// - Halfword extract decode: 011111, 01111, 111000
// - Insert merges low size bits at position
// - Insert upper word copies target bit 31
// - Load address is index plus base
// - Byte load zero-extends one byte
// - Doubleword load faults on misaligned address
// - Loads report all listed memory exceptions
// - Doubleword load decode: 011111, 01000, 001010
// - Plain word extract sign-extends low word
// - Zero shift appends a zero bit
// - Any word overflow sets control bit 23
`timescale 1ns/100ps
`default_nettype none
`include "dax_regs.svh"

module dax_top
#(
	parameter int N_ACC = 4
)
(
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Load unit
	output logic                       mem_req,
	output logic [63:0]                mem_addr,
	output logic                       mem_dword,
	input  wire logic                  mem_ack,
	input  wire logic [63:0]           mem_rdata,
	input  wire dax_pkg::dax_exc_t     mem_exc
);
	import dax_pkg::*;

	// Bus state
	logic              wr_pend_q;
	logic              wr_pend_d;
	logic [7:0]        wr_addr_q;
	logic [7:0]        wr_addr_d;
	logic [31:0]       hrdata_q;
	logic [31:0]       hrdata_d;
	logic [31:0]       rd_mux;
	logic              acc_phase;

	// Software registers
	logic              en_q;
	logic              en_d;
	logic              go_q;
	logic              go_d;
	logic [31:0]       instr_q;
	logic [31:0]       instr_d;
	logic [63:0]       opa_q;
	logic [63:0]       opa_d;
	logic [63:0]       opb_q;
	logic [63:0]       opb_d;
	logic [31:0]       dspctl_q;
	logic [31:0]       dspctl_d;
	logic [31:0]       acc_hi_q [N_ACC];
	logic [31:0]       acc_hi_d [N_ACC];
	logic [31:0]       acc_lo_q [N_ACC];
	logic [31:0]       acc_lo_d [N_ACC];

	// Execution state
	dax_state_t        state_q;
	dax_state_t        state_d;
	logic [63:0]       res_q;
	logic [63:0]       res_d;
	dax_exc_t          exc_q;
	dax_exc_t          exc_d;
	logic              done_q;
	logic              done_d;
	logic [63:0]       maddr_q;
	logic [63:0]       maddr_d;
	logic              mdword_q;
	logic              mdword_d;

	// Decode and datapath
	logic [5:0]        opc;
	logic [5:0]        fn;
	logic [4:0]        sub;
	logic [1:0]        acc_sel;
	logic              is_extract;
	logic              is_insert;
	logic              is_load;
	dax_xop_t          xop;
	logic [63:0]       x_result;
	logic              x_ovf;
	logic [63:0]       ins_result;
	logic [63:0]       ins_mask;
	logic [31:0]       ins_low;
	logic [5:0]        ins_pos;
	logic [5:0]        ins_size;
	logic [63:0]       eff_addr;

	assign acc_phase = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign mem_req   = (state_q == st_mem);
	assign mem_addr  = maddr_q;
	assign mem_dword = mdword_q;

	assign opc     = instr_q[31:26];
	assign fn      = instr_q[5:0];
	assign sub     = instr_q[10:6];
	assign acc_sel = instr_q[12:11];

	// Decode of the supported encodings
	always_comb
	begin
		is_extract = 1'b0;
		is_insert  = 1'b0;
		is_load    = 1'b0;
		xop        = xop_word;
		if (opc == `DAX_OPC_PRIMARY)
		begin
			if (fn == `DAX_FN_EXTRACT && instr_q[15:13] == 3'h0)
			begin
				is_extract = 1'b1;
				unique case (sub)
					`DAX_SUB_XWORD:  xop = xop_word;
					`DAX_SUB_XROUND: xop = xop_round;
					`DAX_SUB_XRSAT:  xop = xop_round_sat;
					`DAX_SUB_XHALF:  xop = xop_half;
					default:         is_extract = 1'b0;
				endcase
			end
			if (fn == `DAX_FN_INSERT && instr_q[15:6] == 10'h0)
				is_insert = 1'b1;
			if (fn == `DAX_FN_LOAD &&
				(sub == `DAX_SUB_LUBYTE || sub == `DAX_SUB_LDWORD))
				is_load = 1'b1;
		end
	end

	// Shift comes from the low five bits of the shift source
	dax_extract u_extract
	(
		.acc    ({acc_hi_q[acc_sel], acc_lo_q[acc_sel]}),
		.shift  (opa_q[4:0]),
		.xop    (xop),
		.result (x_result),
		.ovf    (x_ovf)
	);

	// Out-of-range position or size is left to software
	always_comb
	begin
		ins_pos    = dspctl_q[`DAX_DSP_POS_LSB +: 6];
		ins_size   = dspctl_q[`DAX_DSP_SCOUNT_LSB +: 6];
		ins_mask   = ((64'h1 << ins_size) - 64'h1) << ins_pos;
		ins_low    = (opb_q[31:0] & ~ins_mask[31:0]) |
			(opa_q[31:0] << ins_pos) & ins_mask[31:0];
		ins_result = {{32{opb_q[31]}}, ins_low};
		eff_addr   = opb_q + opa_q;
	end

	// Read mux, sampled in the address phase
	always_comb
	begin
		rd_mux = 32'h0;
		unique case (haddr[7:0])
			`DAX_OFF_CTRL:     rd_mux = {30'h0, en_q, 1'b0};
			`DAX_OFF_INSTR:    rd_mux = instr_q;
			`DAX_OFF_OPA_LO:   rd_mux = opa_q[31:0];
			`DAX_OFF_OPA_HI:   rd_mux = opa_q[63:32];
			`DAX_OFF_OPB_LO:   rd_mux = opb_q[31:0];
			`DAX_OFF_OPB_HI:   rd_mux = opb_q[63:32];
			`DAX_OFF_DSPCTL:   rd_mux = dspctl_q;
			`DAX_OFF_STATUS:   rd_mux = {25'h0, exc_q, 2'h0, done_q, mem_req};
			`DAX_OFF_RES_LO:   rd_mux = res_q[31:0];
			`DAX_OFF_RES_HI:   rd_mux = res_q[63:32];
			`DAX_OFF_MADDR_LO: rd_mux = maddr_q[31:0];
			`DAX_OFF_MADDR_HI: rd_mux = maddr_q[63:32];
			default:
			begin
				for (int i = 0; i < N_ACC; i++)
				begin
					if (haddr[7:0] == `DAX_OFF_ACC_BASE + 8'(8 * i))
						rd_mux = acc_hi_q[i];
					if (haddr[7:0] == `DAX_OFF_ACC_BASE + 8'(8 * i + 4))
						rd_mux = acc_lo_q[i];
				end
			end
		endcase
	end

	// Next-state logic for bus, registers and execution
	always_comb
	begin
		wr_pend_d = acc_phase && hwrite;
		wr_addr_d = acc_phase ? haddr[7:0] : wr_addr_q;
		hrdata_d  = (acc_phase && !hwrite) ? rd_mux : hrdata_q;
		en_d      = en_q;
		go_d      = 1'b0;
		instr_d   = instr_q;
		opa_d     = opa_q;
		opb_d     = opb_q;
		dspctl_d  = dspctl_q;
		acc_hi_d  = acc_hi_q;
		acc_lo_d  = acc_lo_q;
		state_d   = state_q;
		res_d     = res_q;
		exc_d     = exc_q;
		done_d    = done_q;
		maddr_d   = maddr_q;
		mdword_d  = mdword_q;

		if (wr_pend_q)
		begin
			unique case (wr_addr_q)
				`DAX_OFF_CTRL:
				begin
					en_d = hwdata[`DAX_CTRL_EN];
					go_d = hwdata[`DAX_CTRL_GO];
				end
				`DAX_OFF_INSTR:  instr_d         = hwdata;
				`DAX_OFF_OPA_LO: opa_d[31:0]     = hwdata;
				`DAX_OFF_OPA_HI: opa_d[63:32]    = hwdata;
				`DAX_OFF_OPB_LO: opb_d[31:0]     = hwdata;
				`DAX_OFF_OPB_HI: opb_d[63:32]    = hwdata;
				`DAX_OFF_DSPCTL: dspctl_d        = hwdata;
				default:
				begin
					for (int i = 0; i < N_ACC; i++)
					begin
						if (wr_addr_q == `DAX_OFF_ACC_BASE + 8'(8 * i))
							acc_hi_d[i] = hwdata;
						if (wr_addr_q == `DAX_OFF_ACC_BASE + 8'(8 * i + 4))
							acc_lo_d[i] = hwdata;
					end
				end
			endcase
		end

		unique case (state_q)
			st_idle:
			begin
				if (go_q)
				begin
					done_d = 1'b1;
					exc_d  = exc_none;
					if (!en_q)
						exc_d = exc_dsp_disabled;
					else if (!(is_extract || is_insert || is_load))
						exc_d = exc_reserved;
					else if (is_load)
					begin
						mdword_d = (sub == `DAX_SUB_LDWORD);
						if (sub == `DAX_SUB_LDWORD && eff_addr[2:0] != 3'h0)
							exc_d = exc_addr_error;
						else
						begin
							maddr_d = eff_addr;
							state_d = st_mem;
							done_d  = 1'b0;
						end
					end
					else if (is_insert)
						res_d = ins_result;
					else
					begin
						// Accumulators are never written here
						res_d = x_result;
						// Set after any software write so the event wins
						if (x_ovf)
							dspctl_d[`DAX_DSP_OUFLAG] = 1'b1;
					end
				end
			end
			st_mem:
			begin
				if (mem_ack)
				begin
					state_d = st_idle;
					done_d  = 1'b1;
					exc_d   = mem_exc;
					if (mem_exc == exc_none)
						res_d = mdword_q ? mem_rdata :
							{56'h0, mem_rdata[7:0]};
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0;
			en_q      <= `DAX_CTRL_RST;
			go_q      <= 1'b0;
			instr_q   <= 32'h0;
			opa_q     <= 64'h0;
			opb_q     <= 64'h0;
			dspctl_q  <= `DAX_DSPCTL_RST;
			for (int i = 0; i < N_ACC; i++)
			begin
				acc_hi_q[i] <= 32'h0;
				acc_lo_q[i] <= 32'h0;
			end
			state_q   <= st_idle;
			res_q     <= 64'h0;
			exc_q     <= exc_none;
			done_q    <= 1'b0;
			maddr_q   <= 64'h0;
			mdword_q  <= 1'b0;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q  <= hrdata_d;
			en_q      <= en_d;
			go_q      <= go_d;
			instr_q   <= instr_d;
			opa_q     <= opa_d;
			opb_q     <= opb_d;
			dspctl_q  <= dspctl_d;
			acc_hi_q  <= acc_hi_d;
			acc_lo_q  <= acc_lo_d;
			state_q   <= state_d;
			res_q     <= res_d;
			exc_q     <= exc_d;
			done_q    <= done_d;
			maddr_q   <= maddr_d;
			mdword_q  <= mdword_d;
		end
	end

endmodule
`default_nettype wire

// [dax_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module dax_top_sva
#(
	parameter int N_ACC = 4
)
(
	// Bus side
	input wire logic		hclk,
	input wire logic		hresetn,
	input wire logic		hsel,
	input wire logic [1:0]	htrans,
	input wire logic		hwrite,
	input wire logic		hready,
	input wire logic [31:0]	hrdata,
	input wire logic		hreadyout,
	input wire logic		hresp,
	// Load side
	input wire logic		mem_req,
	input wire logic [63:0]	mem_addr,
	input wire logic		mem_dword,
	input wire logic		mem_ack
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	ready_const_a: assert property (hreadyout)
		else $error("wait state on bus");
	resp_okay_a: assert property (!hresp)
		else $error("error response on bus");
	reset_quiet_a: assert property ($rose(hresetn) |-> !mem_req && hrdata == 32'h0)
		else $error("outputs active after reset");
	read_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req)
		else $error("load request dropped early");
	req_drop_a: assert property (mem_req && mem_ack |=> !mem_req [*2])
		else $error("load request kept after answer");
	addr_stable_a: assert property (mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_dword))
		else $error("load address moved while waiting");
	dword_align_a: assert property (mem_req && mem_dword |-> mem_addr[2:0] == 3'h0)
		else $error("misaligned doubleword request");
	load_cov_c: cover property ($rose(mem_req));
	dword_cov_c: cover property (mem_req && mem_ack && mem_dword);
	write_cov_c: cover property (hsel && htrans[1] && hwrite);
endmodule
`default_nettype wire

// [dax_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dax_mem_model
(
	// Clock and reset
	input wire logic				hclk,
	input wire logic				hresetn,
	// Load requests
	input wire logic				mem_req,
	input wire logic [63:0]			mem_addr,
	output logic					mem_ack,
	output logic [63:0]				mem_rdata,
	output dax_pkg::dax_exc_t		mem_exc,
	// Scenario control
	input wire logic [3:0]			delay,
	input wire dax_pkg::dax_exc_t	exc_cmd,
	output int						n_req
);
	import dax_pkg::*;
	logic [3:0]	wait_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{mem_ack, mem_rdata, wait_q, n_req} <= '0;
			mem_exc <= exc_none;
		end
		else
		begin
			// Between answers data and code wander, so a stale sample shows
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			mem_exc <= dax_exc_t'(mem_exc + 3'h1);
			wait_q <= '0;
			if (mem_req && !mem_ack && wait_q < delay)
				wait_q <= wait_q + 4'h1;
			else if (mem_req && !mem_ack)
			begin
				mem_ack <= 1'b1;
				mem_rdata <= {~mem_addr[31:0], mem_addr[31:0] ^ 32'h5a5a_0f0f};
				mem_exc <= exc_cmd;
				n_req <= n_req + 1;
			end
		end
	end
endmodule
`default_nettype wire

// [dax_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dax_regs.svh"
module dax_top_tb;
	import dax_pkg::*;
	logic			hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0]		htrans;
	logic [31:0]	haddr, hwdata, hrdata, seed;
	logic			mem_req, mem_dword, mem_ack, flag_m;
	logic [63:0]	mem_addr, mem_rdata, res_m;
	logic [63:0]	acc_m [4];
	logic [3:0]		delay;
	logic [4:0]		sub [4] = '{`DAX_SUB_XWORD, `DAX_SUB_XROUND, `DAX_SUB_XRSAT, `DAX_SUB_XHALF};
	dax_exc_t		mem_exc, exc_cmd;
	int				n_req, n_errors, num_checks;

	dax_top #(.N_ACC(4)) dax_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_addr,
		.mem_dword, .mem_ack, .mem_rdata, .mem_exc);
	dax_mem_model mem_i (.hclk, .hresetn, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .mem_exc,
		.delay, .exc_cmd, .n_req);

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Returns overflow flag above the 64-bit result
	function automatic logic [64:0] ref_x(logic [63:0] a, logic [4:0] sh, int xop);
		logic [64:0]	t, u;
		logic			o1, o2;
		logic [63:0]	h;
		t = $signed({a, 1'b0}) >>> sh;
		u = t + 65'h1;
		o1 = t[64:32] != 33'h0 && t[64:32] != {33{1'b1}};
		o2 = u[64:32] != 33'h0 && u[64:32] != {33{1'b1}};
		h = $signed(a) >>> sh;
		case (xop)
			0: return {o1 | o2, {32{t[32]}}, t[32:1]};
			1: return {o1 | o2, {32{u[32]}}, u[32:1]};
			2: return {o1 | o2, o2 ? (u[64] ? 64'hffff_ffff_8000_0000 : 64'h7fff_ffff) : {{32{u[32]}}, u[32:1]}};
			default: return $signed(h) > 64'sh7fff ? {1'b1, 64'h7fff} :
				$signed(h) < -64'sh8000 ? {1'b1, 64'hffff_ffff_ffff_8000} : {1'b0, h};
		endcase
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic rdy();
		for (int k = 0; k < 50; k++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		n_errors++;
		print_verdict();
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
		rdy();
		{hsel, htrans, hwdata} <= {3'b000, d};
		rdy();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	task automatic wr64(input logic [7:0] a, input logic [63:0] v);
		wr(a, v[31:0]);
		wr(a + 8'h4, v[63:32]);
	endtask

	task automatic rd64(input logic [7:0] a, output logic [63:0] v);
		rd(a, v[31:0]);
		rd(a + 8'h4, v[63:32]);
	endtask

	task automatic wacc(input int n, input logic [63:0] v);
		wr(8'(32 + 8 * n), v[63:32]);
		wr(8'(36 + 8 * n), v[31:0]);
		acc_m[n] = v;
	endtask

	task automatic run(input logic [31:0] ins, input logic [1:0] ctl, input logic [2:0] exc);
		logic [31:0]	s;
		logic [63:0]	v;
		wr(`DAX_OFF_INSTR, ins);
		wr(`DAX_OFF_CTRL, {30'h0, ctl});
		// Decode lags the go write by one edge, so busy is not yet visible
		repeat (2) @(posedge hclk);
		for (int k = 0; k < 40; k++)
		begin
			rd(`DAX_OFF_STATUS, s);
			if (s[0] === 1'b0)
				break;
		end
		// A load that never finishes ends the run here
		if (s[0] !== 1'b0)
		begin
			n_errors++;
			print_verdict();
		end
		chk(64'({s[6:4], s[1:0]}), 64'({exc, 2'b10}), "status");
		rd64(`DAX_OFF_RES_LO, v);
		chk(v, res_m, "result");
		rd(`DAX_OFF_DSPCTL, s);
		chk(64'(s[23]), 64'(flag_m), "flag");
	endtask

	initial
	begin : main
		logic [31:0]	a;
		logic [63:0]	b, x, ea, d;
		logic [64:0]	r;
		logic [2:0]		e;
		int				p, sz, ac;
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, flag_m, res_m} = '0;
		{n_errors, num_checks} = '0;
		exc_cmd = exc_none;
		delay = 4'h0;
		seed = 32'd59;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		wr(8'h50, 32'hffff_ffff);
		rd(8'h50, a);
		chk(64'(a), 64'h0, "unmapped");
		rd(`DAX_OFF_DSPCTL, a);
		chk(64'(a), 64'(`DAX_DSPCTL_RST), "control reset");
		$display("test bus done");
		for (int i = 0; i < 4; i++)
			wacc(i, {rnd(), rnd()});
		for (int i = 0; i < 40; i++)
		begin
			ac = int'(rnd() % 4);
			b = {rnd(), rnd()};
			b = $signed(b) >>> (rnd() % 48);
			wacc(ac, b);
			a = rnd();
			if (i < 8)
				a[4:0] = (i < 4) ? 5'h0 : 5'h1f;
			wr(`DAX_OFF_OPA_LO, a);
			if (i % 8 == 0)
			begin
				wr(`DAX_OFF_DSPCTL, 32'h0);
				flag_m = 1'b0;
			end
			r = ref_x(b, a[4:0], i % 4);
			res_m = r[63:0];
			flag_m = flag_m | r[64];
			run({`DAX_OPC_PRIMARY, 10'h0, 3'h0, 2'(ac), sub[i % 4], `DAX_FN_EXTRACT}, 2'h3, 3'h0);
		end
		$display("test extract done");
		for (int i = 0; i < 10; i++)
		begin
			p = (i == 0) ? 0 : (i == 1) ? 31 : int'(rnd() % 32);
			sz = (i == 0) ? 32 : 1 + int'(rnd() % (32 - p));
			x = 64'($signed(rnd()));
			b = 64'($signed(rnd()));
			wr64(`DAX_OFF_OPA_LO, x);
			wr64(`DAX_OFF_OPB_LO, b);
			wr(`DAX_OFF_DSPCTL, {8'h0, flag_m, 10'h0, 6'(sz), 1'b0, 6'(p)});
			ea = ((64'h1 << sz) - 64'h1) << p;
			ea = (b & ~ea) | ((x << p) & ea);
			res_m = {{32{b[31]}}, ea[31:0]};
			run({`DAX_OPC_PRIMARY, 20'h0, `DAX_FN_INSERT}, 2'h3, 3'h0);
		end
		$display("test insert done");
		for (int i = 0; i < 15; i++)
		begin
			b = {rnd(), rnd() & 32'hffff_fff8};
			x = {rnd(), rnd()};
			x[2:0] = (i % 3 == 1) ? 3'h0 : (i % 3 == 2) ? 3'(1 + rnd() % 7) : x[2:0];
			ea = b + x;
			d = {~ea[31:0], ea[31:0] ^ 32'h5a5a_0f0f};
			e = (i % 3 == 2) ? 3'h6 : (i < 9) ? 3'h0 : 3'(3 + i % 5);
			delay <= 4'(rnd() % 6);
			exc_cmd <= dax_exc_t'((i < 9) ? 3'h0 : 3'(3 + i % 5));
			wr64(`DAX_OFF_OPA_LO, b);
			wr64(`DAX_OFF_OPB_LO, x);
			p = n_req;
			if (e == 3'h0)
				res_m = (i % 3 == 0) ? {56'h0, d[7:0]} : d;
			run({`DAX_OPC_PRIMARY, 15'h0, (i % 3 == 0) ? `DAX_SUB_LUBYTE : `DAX_SUB_LDWORD, `DAX_FN_LOAD}, 2'h3, e);
			chk(64'(n_req - p), (i % 3 == 2) ? 64'h0 : 64'h1, "requests");
			chk(64'(mem_dword), (i % 3 == 0) ? 64'h0 : 64'h1, "size");
			rd64(`DAX_OFF_MADDR_LO, x);
			if (i % 3 != 2)
				chk(x, ea, "address");
		end
		$display("test load done");
		run({`DAX_OPC_PRIMARY, 15'h0, `DAX_SUB_XWORD, `DAX_FN_EXTRACT}, 2'h1, 3'h2);
		run({`DAX_OPC_PRIMARY, 15'h0, 5'h02, `DAX_FN_EXTRACT}, 2'h3, 3'h1);
		for (int i = 0; i < 4; i++)
		begin
			rd(8'(32 + 8 * i), d[63:32]);
			rd(8'(36 + 8 * i), d[31:0]);
			chk(d, acc_m[i], "accumulator");
		end
		$display("test refusal done");
		print_verdict();
	end
endmodule
bind dax_top dax_top_sva #(.N_ACC(N_ACC)) sva_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .mem_req, .mem_addr, .mem_dword, .mem_ack);
`default_nettype wire
